// >>> dbu_pkg.sv
package dbu_pkg;

  // ---------------------------------------------------------------
  // opcodes and command bytes
  // ---------------------------------------------------------------
  localparam logic [7:0] OP_BRK      = 8'h00;
  localparam logic [7:0] CMD_REV     = 8'h00;
  localparam logic [7:0] CMD_STAT    = 8'h02;
  localparam logic [7:0] CMD_RUNT    = 8'h03;
  localparam logic [7:0] CMD_WR_CTRL = 8'h04;
  localparam logic [7:0] CMD_WR_REG  = 8'h08;
  localparam logic [7:0] CMD_RD_REG  = 8'h09;
  localparam logic [7:0] CMD_WR_PM   = 8'h0a;
  localparam logic [7:0] CMD_RD_PM   = 8'h0b;
  localparam logic [7:0] CMD_WR_DM   = 8'h0c;
  localparam logic [7:0] CMD_RD_DM   = 8'h0d;
  localparam logic [7:0] CMD_PM_CRC  = 8'h0e;
  localparam logic [7:0] CMD_STEP    = 8'h10;
  localparam logic [7:0] CMD_STUFF   = 8'h11;
  localparam logic [7:0] CMD_EXEC    = 8'h12;

  // ---------------------------------------------------------------
  // control and status fields
  // ---------------------------------------------------------------
  localparam int         CTRL_DBG_BIT   = 7;
  localparam int         CTRL_BRKEN_BIT = 6;
  localparam logic       BRKEN_RESET    = 1'b0;
  localparam int         STAT_DBG_BIT   = 7;
  localparam int         STAT_BUSY_BIT  = 6;
  localparam int         STAT_RDP_BIT   = 5;

  // ---------------------------------------------------------------
  // flash control window and counter limits
  // ---------------------------------------------------------------
  localparam logic [11:0] FCTL_FIRST  = 12'hff8;
  localparam logic [11:0] FCTL_LAST   = 12'hffb;
  localparam logic [11:0] FCTL_CMD    = 12'hff8;
  localparam logic [7:0]  MASS_ERASE  = 8'h95;
  localparam logic [15:0] RUNT_RESET  = 16'h0000;
  localparam logic [15:0] RUNT_MAX    = 16'hffff;
  localparam logic [1:0]  WR_REG_ARGS = 2'h3;
  localparam logic [1:0]  CTRL_ARGS   = 2'h1;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ARG  = 2'b01,
    ST_TX   = 2'b10,
    ST_ENG  = 2'b11
  } dbu_state_e;

endpackage

// >>> dbu_core.sv
`timescale 1ns/1ps

// Summary of operation
// R01: cpu decode of opcode 00h raises an internal breakpoint signal.
// R02: breakpoints enabled: breakpoint enters debug mode and halts fetching.
// R03: breakpoints disabled: breakpoint ignored, opcode acts as no-op.
// R04: commands 08h..12h accepted only while in debug mode.
// R05: read protect: register write only to flash control registers.
// R06: read protect: flash command register accepts only mass erase value.
// R07: read protect: register read, pm access, dm write, step/stuff/exec off.
// R08: data memory read and program CRC stay usable under read protect.
// R09: revision command returns 16-bit revision, major byte then minor.
// R10: status command returns one status byte.
// R11: 16-bit runtime counter counts clocks outside debug mode, saturates at ffffh.
// R12: runtime command returns the counter value.
// R13: erased memory (ffh opcodes) must not block flash programming.
// R14: in debug mode fetch stays stopped unless told to execute.
// R15: in debug mode watchdog refreshed continuously when enabled.
// R16: debug pin low at reset release enters debug mode at once.
// R17: control write with 80h enters debug mode.
// R18: reserved command bytes ignored, no state change, no answer.
// R19: runtime counter cleared when execution resumes.
module dbu_core
  import dbu_pkg::*;
#(
  parameter logic [15:0] DBG_REV = 16'h0102  // arbitrary value
) (
  input  wire logic        core_clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        debug_serial_pin_i,
  input  wire logic        rd_protect_i,
  input  wire logic        wdt_enable_i,
  input  wire logic        cpu_decode_i,
  input  wire logic [7:0]  cpu_opcode_i,
  input  wire logic        rx_valid_i,
  input  wire logic [7:0]  rx_data_i,
  input  wire logic        tx_ready_i,
  input  wire logic        eng_done_i,
  output logic             tx_valid_o,
  output logic [7:0]       tx_data_o,
  output logic             debug_mode_o,
  output logic             brk_enable_o,
  output logic             cpu_fetch_stop_o,
  output logic             brk_nop_o,
  output logic             wdt_refresh_o,
  output logic             reg_wr_o,
  output logic [11:0]      reg_wr_addr_o,
  output logic [7:0]       reg_wr_data_o,
  output logic             eng_start_o,
  output logic [7:0]       eng_cmd_o,
  output logic             cpu_exec_o,
  output logic [15:0]      runtime_o
);

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  dbu_state_e  state;
  logic        debug_mode;
  logic        brk_en;
  logic        rst_done;
  logic [15:0] runtime;
  logic [7:0]  cmd;
  logic [1:0]  arg_cnt;
  logic [23:0] arg_buf;
  logic [7:0]  resp_lo;
  logic        resp_two;
  logic        eng_cpu;
  logic        take;
  logic        brk_hit;
  logic        ctrl_wr;
  logic        resume;
  logic        last_arg;
  logic [23:0] args;
  logic [11:0] wr_addr;
  logic        wr_ok;
  logic        dbg_cmd;
  logic        rdp_blocked;
  logic        eng_cmd;
  logic [7:0]  status;

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  assign brk_hit  = cpu_decode_i && (cpu_opcode_i == OP_BRK);  // R01 R13
  assign take     = rx_valid_i && (state == ST_IDLE || state == ST_ARG);
  assign last_arg = take && (state == ST_ARG) && (arg_cnt == 2'h1);
  assign args     = {arg_buf[15:0], rx_data_i};
  assign ctrl_wr  = last_arg && (cmd == CMD_WR_CTRL);
  assign resume   = ctrl_wr && debug_mode && !rx_data_i[CTRL_DBG_BIT]
                    && !(brk_hit && brk_en);
  assign wr_addr  = args[19:8];
  assign dbg_cmd  = (rx_data_i >= CMD_WR_REG) && (rx_data_i <= CMD_EXEC)
                    && (rx_data_i != 8'h0f);  // R18
  assign eng_cmd  = dbg_cmd && (rx_data_i != CMD_WR_REG);
  assign rdp_blocked = rd_protect_i && (rx_data_i != CMD_RD_DM)
                       && (rx_data_i != CMD_PM_CRC);  // R07 R08

  always_comb begin
    wr_ok = 1'b1;
    if (rd_protect_i) begin
      wr_ok = (wr_addr >= FCTL_FIRST) && (wr_addr <= FCTL_LAST);  // R05
      if (wr_addr == FCTL_CMD && args[7:0] != MASS_ERASE) begin
        wr_ok = 1'b0;  // R06
      end
    end
  end

  always_comb begin
    status                = 8'h00;
    status[STAT_DBG_BIT]  = debug_mode;
    status[STAT_BUSY_BIT] = (state == ST_ENG);
    status[STAT_RDP_BIT]  = rd_protect_i;
  end

  // ---------------------------------------------------------------
  // debug mode and breakpoint enable
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rst_done <= 1'b0;
    end else begin
      rst_done <= 1'b1;
    end
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      debug_mode <= 1'b0;
    end else if (!rst_done && !debug_serial_pin_i) begin
      debug_mode <= 1'b1;  // R16
    end else if (brk_hit && brk_en) begin
      debug_mode <= 1'b1;  // R02
    end else if (ctrl_wr) begin
      debug_mode <= rx_data_i[CTRL_DBG_BIT];  // R17
    end
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      brk_en <= BRKEN_RESET;
    end else if (ctrl_wr) begin
      brk_en <= rx_data_i[CTRL_BRKEN_BIT];
    end
  end

  // ---------------------------------------------------------------
  // runtime counter
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      runtime <= RUNT_RESET;
    end else if (resume) begin
      runtime <= RUNT_RESET;  // R19
    end else if (!debug_mode && runtime != RUNT_MAX) begin
      runtime <= runtime + 16'h0001;  // R11
    end
  end

  // ---------------------------------------------------------------
  // command sequencer and answers
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state         <= ST_IDLE;
      cmd           <= 8'h00;
      arg_cnt       <= 2'h0;
      arg_buf       <= 24'h000000;
      tx_valid_o    <= 1'b0;
      tx_data_o     <= 8'h00;
      resp_lo       <= 8'h00;
      resp_two      <= 1'b0;
      reg_wr_o      <= 1'b0;
      reg_wr_addr_o <= 12'h000;
      reg_wr_data_o <= 8'h00;
      eng_start_o   <= 1'b0;
      eng_cmd_o     <= 8'h00;
      eng_cpu       <= 1'b0;
    end else begin
      reg_wr_o    <= 1'b0;
      eng_start_o <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (take) begin
            cmd <= rx_data_i;
            if (rx_data_i == CMD_REV) begin
              tx_valid_o <= 1'b1;  // R09
              tx_data_o  <= DBG_REV[15:8];
              resp_lo    <= DBG_REV[7:0];
              resp_two   <= 1'b1;
              state      <= ST_TX;
            end else if (rx_data_i == CMD_STAT) begin
              tx_valid_o <= 1'b1;  // R10
              tx_data_o  <= status;
              resp_two   <= 1'b0;
              state      <= ST_TX;
            end else if (rx_data_i == CMD_RUNT) begin
              tx_valid_o <= 1'b1;  // R12
              tx_data_o  <= runtime[15:8];
              resp_lo    <= runtime[7:0];
              resp_two   <= 1'b1;
              state      <= ST_TX;
            end else if (rx_data_i == CMD_WR_CTRL) begin
              arg_cnt <= CTRL_ARGS;
              state   <= ST_ARG;
            end else if (rx_data_i == CMD_WR_REG && debug_mode) begin
              arg_cnt <= WR_REG_ARGS;  // R04
              state   <= ST_ARG;
            end else if (eng_cmd && debug_mode && !rdp_blocked) begin
              eng_start_o <= 1'b1;  // R04 R07 R08
              eng_cmd_o   <= rx_data_i;
              eng_cpu     <= (rx_data_i >= CMD_STEP);  // R14
              state       <= ST_ENG;
            end
          end
        end
        ST_ARG: begin
          if (take) begin
            arg_buf <= args;
            arg_cnt <= arg_cnt - 2'h1;
            if (arg_cnt == 2'h1) begin
              state <= ST_IDLE;
              if (cmd == CMD_WR_REG && wr_ok) begin
                reg_wr_o      <= 1'b1;  // R05 R06
                reg_wr_addr_o <= wr_addr;
                reg_wr_data_o <= args[7:0];
              end
            end
          end
        end
        ST_TX: begin
          if (tx_ready_i) begin
            if (resp_two) begin
              tx_data_o <= resp_lo;  // R09
              resp_two  <= 1'b0;
            end else begin
              tx_valid_o <= 1'b0;
              state      <= ST_IDLE;
            end
          end
        end
        ST_ENG: begin
          if (eng_done_i) begin
            eng_cpu <= 1'b0;
            state   <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // cpu side
  // ---------------------------------------------------------------
  assign debug_mode_o     = debug_mode;
  assign brk_enable_o     = brk_en;
  assign runtime_o        = runtime;
  assign cpu_exec_o       = (state == ST_ENG) && eng_cpu;
  assign cpu_fetch_stop_o = debug_mode && !cpu_exec_o;  // R02 R14
  assign brk_nop_o        = brk_hit && !brk_en;  // R03
  assign wdt_refresh_o    = debug_mode && wdt_enable_i;  // R15

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  property p_brk_halt;
    @(posedge core_clk_i) disable iff (sys_rst_i)
    brk_hit && brk_en |=> debug_mode_o && cpu_fetch_stop_o;
  endproperty
  a_brk_halt: assert property (p_brk_halt)  // R02
    else $error("breakpoint did not halt");

  property p_brk_nop;
    @(posedge core_clk_i) disable iff (sys_rst_i)
    brk_hit && !brk_en && !debug_mode && !ctrl_wr && rst_done
      |-> brk_nop_o ##1 !debug_mode_o;
  endproperty
  a_brk_nop: assert property (p_brk_nop)  // R03
    else $error("disabled breakpoint had effect");

  property p_gate;
    @(posedge core_clk_i) disable iff (sys_rst_i)
    take && state == ST_IDLE && !debug_mode && dbg_cmd
      |=> state == ST_IDLE && !eng_start_o;
  endproperty
  a_gate: assert property (p_gate)  // R04
    else $error("debug command taken outside debug mode");

  property p_rdp_addr;
    @(posedge core_clk_i) disable iff (sys_rst_i)
    reg_wr_o && $past(rd_protect_i)
      |-> reg_wr_addr_o >= FCTL_FIRST && reg_wr_addr_o <= FCTL_LAST;
  endproperty
  a_rdp_addr: assert property (p_rdp_addr)  // R05
    else $error("protected write outside flash control");

  property p_rdp_erase;
    @(posedge core_clk_i) disable iff (sys_rst_i)
    reg_wr_o && $past(rd_protect_i) && reg_wr_addr_o == FCTL_CMD
      |-> reg_wr_data_o == MASS_ERASE;
  endproperty
  a_rdp_erase: assert property (p_rdp_erase)  // R06
    else $error("protected flash command not mass erase");

  property p_rdp_eng;
    @(posedge core_clk_i) disable iff (sys_rst_i)
    eng_start_o && $past(rd_protect_i)
      |-> eng_cmd_o == CMD_RD_DM || eng_cmd_o == CMD_PM_CRC;
  endproperty
  a_rdp_eng: assert property (p_rdp_eng)  // R07
    else $error("protected command reached engine");

  property p_rev;
    @(posedge core_clk_i) disable iff (sys_rst_i)
    take && state == ST_IDLE && rx_data_i == CMD_REV
      |=> tx_valid_o && tx_data_o == DBG_REV[15:8];
  endproperty
  a_rev: assert property (p_rev)  // R09
    else $error("revision major byte wrong");

  property p_sat;
    @(posedge core_clk_i) disable iff (sys_rst_i)
    runtime == RUNT_MAX && !resume |=> runtime == RUNT_MAX;
  endproperty
  a_sat: assert property (p_sat)  // R11
    else $error("runtime counter wrapped");

  property p_resume;
    @(posedge core_clk_i) disable iff (sys_rst_i)
    resume |=> runtime == RUNT_RESET ##1 runtime == 16'h0001;
  endproperty
  a_resume: assert property (p_resume)  // R19
    else $error("runtime not restarted on resume");

endmodule

// >>> dbu_host_model.sv
`timescale 1ns/1ps
module dbu_host_model (
  input  wire logic       core_clk_i,
  input  wire logic       tx_valid_i,
  input  wire logic [7:0] tx_data_i,
  output logic            rx_valid_o,
  output logic [7:0]      rx_data_o,
  output logic            tx_ready_o
);
  int stall = 0;
  initial begin
    rx_valid_o = 1'b0;
    rx_data_o  = 8'h5a;
    tx_ready_o = 1'b0;
  end
  // n bytes msb first, strobe held between them
  task automatic send(input logic [31:0] b, input int n);
    @(posedge core_clk_i);
    for (int k = n - 1; k >= 0; k--) begin
      rx_valid_o <= 1'b1;
      rx_data_o  <= b[8*k+:8];
      @(posedge core_clk_i);
    end
    rx_valid_o <= 1'b0;
    rx_data_o  <= ~rx_data_o;
  endtask
  // bytes shift in from the low end
  task automatic recv(input int cnt, output logic [15:0] v);
    int n;
    v = 16'h0000;
    for (int k = 0; k < cnt; k++) begin
      if (stall > 0) begin
        tx_ready_o <= 1'b0;
        repeat (stall) @(posedge core_clk_i);
      end
      tx_ready_o <= 1'b1;
      n = 0;
      do begin
        @(posedge core_clk_i);
        n++;
      end while (tx_valid_i !== 1'b1 && n < 20);
      v = {v[7:0], tx_data_i};
    end
    tx_ready_o <= 1'b0;
  endtask
endmodule

// >>> tb_dbu_core.sv
`timescale 1ns/1ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin mismatches++; \
  $display("[ERR] %0t got %0h exp %0h", $time, (a), (e)); end end
module tb_dbu_core;
  import dbu_pkg::*;
  localparam logic [15:0] REV = 16'h5a3c;  // arbitrary value
  logic        clk, rst, pin, prot, wdt, dec, done;
  logic        rxv, txr, txv, dbg, brk_en, stop, nop, wref;
  logic        regw, est, exec;
  logic [7:0]  op, rxd, txd, wd, ecmd;
  logic [11:0] wa;
  logic [15:0] rt, v;
  logic [2:0]  seen;
  int          mismatches = 0;
  int          checked = 0;

  dbu_core #(.DBG_REV(REV)) i_dbu_core (
    .core_clk_i(clk), .sys_rst_i(rst), .debug_serial_pin_i(pin),
    .rd_protect_i(prot), .wdt_enable_i(wdt), .cpu_decode_i(dec),
    .cpu_opcode_i(op), .rx_valid_i(rxv), .rx_data_i(rxd),
    .tx_ready_i(txr), .eng_done_i(done), .tx_valid_o(txv),
    .tx_data_o(txd), .debug_mode_o(dbg), .brk_enable_o(brk_en),
    .cpu_fetch_stop_o(stop), .brk_nop_o(nop), .wdt_refresh_o(wref),
    .reg_wr_o(regw), .reg_wr_addr_o(wa), .reg_wr_data_o(wd),
    .eng_start_o(est), .eng_cmd_o(ecmd), .cpu_exec_o(exec),
    .runtime_o(rt));
  dbu_host_model i_dbu_host_model (
    .core_clk_i(clk), .tx_valid_i(txv), .tx_data_i(txd),
    .rx_valid_o(rxv), .rx_data_o(rxd), .tx_ready_o(txr));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic conclude();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic tx(input logic [31:0] b, input int n);
    i_dbu_host_model.send(b, n);
  endtask
  task automatic rx(input int n);
    i_dbu_host_model.recv(n, v);
  endtask
  // pulses seen over the three cycles after a command
  task automatic watch();
    seen = 3'b000;
    repeat (3) begin
      #1;
      seen = seen | {exec & ~stop, regw, est};
      @(posedge clk);
    end
  endtask
  task automatic finish_eng();
    done <= 1'b1;
    tick(1);
    done <= 1'b0;
    tick(1);
  endtask
  task automatic ctrl(input logic [7:0] d);
    tx({CMD_WR_CTRL, d}, 2);
    tick(2);
    #1;
  endtask

  task automatic t_count();
    logic [15:0] r0;
    #1;
    `CHK(dbg, 1'b0)
    `CHK(wref, 1'b0)
    r0 = rt;
    tick(100);
    #1;
    `CHK(16'(rt - r0), 16'h0064)
    tick(66000);
    #1;
    `CHK(rt, RUNT_MAX)
    tx(32'(CMD_RUNT), 1);
    rx(2);
    `CHK(v, RUNT_MAX)
  endtask
  task automatic t_rev();
    i_dbu_host_model.stall = 2;
    tx(32'(CMD_REV), 1);
    rx(2);
    `CHK(v, REV)
    i_dbu_host_model.stall = 0;
  endtask
  task automatic t_refused();
    logic [7:0] l[12] = '{8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h0d,
                          8'h0e, 8'h10, 8'h12, 8'h0f, 8'h13, 8'hff};
    prot <= 1'b1;
    foreach (l[k]) begin
      tx(32'(l[k]), 1);
      watch();
      `CHK(seen, 3'b000)
      `CHK(txv, 1'b0)
    end
    tx(32'(CMD_STAT), 1);
    rx(1);
    `CHK(v[7:0], 8'h20)
  endtask
  task automatic t_ctrl();
    ctrl(8'h80);
    `CHK(dbg, 1'b1)
    `CHK(stop, 1'b1)
    `CHK(wref, 1'b1)
    tick(1);
    wdt <= 1'b0;
    #1;
    `CHK(wref, 1'b0)
    tick(1);
    wdt <= 1'b1;
  endtask
  task automatic t_engine();
    logic [7:0] l[9] = '{8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h0e,
                         8'h10, 8'h11, 8'h12};
    logic       ok;
    for (int p = 0; p < 2; p++) begin
      prot <= p[0];
      foreach (l[k]) begin
        ok = !p[0] || l[k] == CMD_RD_DM || l[k] == CMD_PM_CRC;
        tx(32'(l[k]), 1);
        watch();
        `CHK(seen[0], ok)
        `CHK(seen[2], ok && l[k] >= CMD_STEP)
        if (ok) `CHK(ecmd, l[k])
        finish_eng();
      end
    end
  endtask
  task automatic t_wreg();
    logic [20:0] l[5] = '{{1'b1, 12'hff8, 8'h95}, {1'b0, 12'hff8, 8'h12},
                          {1'b1, 12'hffb, 8'h33}, {1'b0, 12'h100, 8'h5a},
                          {1'b1, 12'h100, 8'h5a}};
    op <= 8'hff;
    dec <= 1'b1;
    foreach (l[k]) begin
      prot <= k < 4;
      tx({CMD_WR_REG, 4'h0, l[k][19:0]}, 4);
      watch();
      `CHK(seen[1], l[k][20])
      if (l[k][20]) `CHK({wa, wd}, l[k][19:0])
    end
    dec <= 1'b0;
  endtask
  task automatic t_brk();
    ctrl(8'h40);
    `CHK(dbg, 1'b0)
    `CHK(brk_en, 1'b1)
    `CHK(rt < 16'h0008, 1'b1)
    tick(1);
    op <= OP_BRK;
    dec <= 1'b1;
    #1;
    `CHK(nop, 1'b0)
    tick(1);
    dec <= 1'b0;
    tick(1);
    #1;
    `CHK(dbg, 1'b1)
    `CHK(stop, 1'b1)
    ctrl(8'h00);
    tick(1);
    dec <= 1'b1;
    #1;
    `CHK(nop, 1'b1)
    tick(1);
    dec <= 1'b0;
    tick(2);
    #1;
    `CHK(dbg, 1'b0)
    `CHK(stop, 1'b0)
  endtask
  task automatic t_pin();
    tick(1);
    pin <= 1'b0;
    rst <= 1'b1;
    tick(2);
    rst <= 1'b0;
    tick(2);
    #1;
    `CHK(dbg, 1'b1)
    `CHK(rt, 16'h0001)
    tx(32'(CMD_RUNT), 1);
    rx(2);
    `CHK(v, 16'h0001)
  endtask

  initial begin
    rst = 1'b1;
    pin = 1'b1;
    prot = 1'b0;
    wdt = 1'b1;
    dec = 1'b0;
    done = 1'b0;
    op = 8'h00;
    tick(6);
    rst <= 1'b0;
    tick(2);
    t_count();
    t_rev();
    t_refused();
    t_ctrl();
    t_engine();
    t_wreg();
    t_brk();
    t_pin();
    conclude();
  end
  initial begin
    #8000000;
    mismatches++;
    conclude();
  end
endmodule
